// ---- rtl/acp_regs.svh ----
// constants for the serial command port: addresses, fields, command
// codes and bit counts; included by the fifo and port design files
`ifndef ACP_REGS_SVH
`define ACP_REGS_SVH

// configuration register addresses
`define ACP_ADDR_INPUT_GAIN 2'h0
`define ACP_ADDR_RATE_MODE 2'h1
`define ACP_ADDR_REF_FILTER 2'h2
`define ACP_ADDR_ROUTE_READY 2'h3
`define ACP_CFG_COUNT 4
`define ACP_CFG_RESET 8'h00

// fields of input_gain_config and current_route_ready_config
`define ACP_MUX_HI 7
`define ACP_MUX_LO 4
`define ACP_GAIN_HI 3
`define ACP_GAIN_LO 1
`define ACP_BYPASS_BIT 0
`define ACP_READY_SEL_BIT 1
`define ACP_GAIN_MAX_BYPASS 3'h2

// command opcodes, upper nibble of the command byte
`define ACP_OP_RDATA 4'h1
`define ACP_OP_REGISTER_READ_CMD 4'h2
`define ACP_OP_REGISTER_WRITE_CMD 4'h4

// bit counts on the link
`define ACP_BYTE_LAST 3'h7
`define ACP_BYTE_FIRST 3'h0
`define ACP_RESULT_BITS 5'h10
`define ACP_RESULT_REST 5'h0F
`define ACP_REG_REST 5'h07
`define ACP_TAIL_REST 5'h0F
`define ACP_TAIL_HIGH_FROM 5'h08

// result path
`define ACP_RESULT_WIDTH 16
`define ACP_FIFO_DEPTH 16

`endif

// ---- rtl/acp_pkg.sv ----
// types shared by the serial command port files
// assumes acp_regs.svh supplies the numeric constants
package acp_pkg;

  // what the output shifter is doing
  typedef enum logic [2:0] {
    OUT_IDLE,
    OUT_CONV,
    OUT_RDATA,
    OUT_REGISTER_READ_CMD,
    OUT_TAIL
  } acp_out_mode_t;

  // how the next received byte is taken
  typedef enum logic {
    IN_CMD,
    IN_WDATA
  } acp_in_mode_t;

  typedef logic [7:0] acp_byte_t;

endpackage : acp_pkg

// ---- rtl/acp_fifo.sv ----
// result buffer between the converter core and the serial port
// assumes one clock, synchronous active-high reset, power-of-two depth
`timescale 1ns/1ps
`default_nettype none
`include "acp_regs.svh"

module acp_fifo
  import acp_pkg::*;
#(
  parameter int WIDTH = `ACP_RESULT_WIDTH,
  parameter int DEPTH = `ACP_FIFO_DEPTH
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
  logic [AW:0] count, next_count;
  logic next_in_ready;
  logic push, pop;

  ////////////////////////////////////////////////////////////////////////
  // pointer and level arithmetic; ready is registered so it can leave
  // the top as a flop output
  always_comb begin
    push = in_valid & in_ready;
    pop = out_valid & out_ready;
    next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
    next_count = count;
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
    next_in_ready = next_count != FULL;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      in_ready <= 1'b0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
      in_ready <= next_in_ready;
    end
  end

  // storage needs no reset; empty slots are never presented
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  assign out_valid = count != '0;
  assign out_data = mem[rd_ptr];

endmodule : acp_fifo
`default_nettype wire

// ---- rtl/acp_port.sv ----
// serial command port and configuration bank of the converter
// assumes SCLK, CS_N and DIN come from another clock domain; the
// converter core hands results in over a valid/ready pair on CORE_CLK
//
// Contract
// - conversion read runs while incoming bytes are still decoded as commands
// - read-data or register-read arriving during a conversion read aborts it
// - requested data starts at the first rising edge after the command
// - register write during a conversion read leaves its output alone
// - completed register write restarts the filter with new settings
// - read-data and register-read block further commands until finished
// - combined line is released whenever chip select is high
// - dedicated ready pin is always driven
// - with ready-on-out set, combined line shows ready once selected
// - after a result read, line is low eight clocks then high eight
// - four byte registers reached only through register commands
// - registers clear on reset and hold through power-down
// - register zero holds input select, gain code and bypass bit
// - gain code selects gain of two to the code
// - amplifier stays on for gains eight and above
// - bypass bit zero enables amplifier, one bypasses it below gain eight
// - register map at addresses zero to three as documented
// - command byte opcodes with start address and count minus one
// - register commands end after count plus one data bytes
// - written registers take effect on the last falling edge
// - results leave msb first on rising edges; ready falls on new result
`timescale 1ns/1ps
`default_nettype none
`include "acp_regs.svh"

module acp_port
  import acp_pkg::*;
#(
  parameter int FIFO_DEPTH = `ACP_FIFO_DEPTH
) (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic SYS_RST,
  // serial link, mode 1
  input wire logic SCLK,
  input wire logic CS_N,
  input wire logic DIN,
  output logic DOUT_O,
  output logic DOUT_OE,
  output logic RDY_N,
  // conversion results from the converter core
  input wire logic RESULT_VALID,
  output logic RESULT_READY,
  input wire logic [`ACP_RESULT_WIDTH-1:0] RESULT_DATA,
  // configuration towards the converter core
  output logic [7:0] CFG_INPUT_GAIN,
  output logic [7:0] CFG_RATE_MODE,
  output logic [7:0] CFG_REF_FILTER,
  output logic [7:0] CFG_ROUTE_READY,
  output logic [7:0] GAIN_FACTOR,
  output logic AMP_ENABLE,
  output logic FILTER_RESTART
);

  ////////////////////////////////////////////////////////////////////////
  // helpers

  // gain is two to the code, so the code is a plain shift
  function automatic acp_byte_t gain_of(input logic [2:0] code);
    gain_of = 8'h01 << code;
  endfunction : gain_of

  // bypass only bites at the three lowest gains
  function automatic logic amp_on(input acp_byte_t cfg0);
    amp_on = !(cfg0[`ACP_BYPASS_BIT] &&
      cfg0[`ACP_GAIN_HI:`ACP_GAIN_LO] <= `ACP_GAIN_MAX_BYPASS);
  endfunction : amp_on

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers; stage 0 feeds only stage 1

  logic [2:0] sclk_s, next_sclk_s;
  logic [1:0] cs_s, next_cs_s, din_s, next_din_s;
  logic rise, fall, selected, din_bit;

  always_comb begin
    next_sclk_s = {sclk_s[1:0], SCLK};
    next_cs_s = {cs_s[0], CS_N};
    next_din_s = {din_s[0], DIN};
  end

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      sclk_s <= 3'h0;
      cs_s <= 2'h3;
      din_s <= 2'h0;
    end else begin
      sclk_s <= next_sclk_s;
      cs_s <= next_cs_s;
      din_s <= next_din_s;
    end
  end

  // edges come from the second and third stage only
  assign selected = !cs_s[1];
  assign din_bit = din_s[1];
  assign rise = selected && sclk_s[1] && !sclk_s[2];
  assign fall = selected && !sclk_s[1] && sclk_s[2];

  ////////////////////////////////////////////////////////////////////////
  // result buffer; a new word is taken only after the last one was read,
  // so an unread host lets the buffer fill and stalls the core

  logic fifo_valid, fifo_pop;
  logic [`ACP_RESULT_WIDTH-1:0] fifo_data;

  acp_fifo #(
    .WIDTH(`ACP_RESULT_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(CORE_CLK),
    .rst(SYS_RST),
    .in_valid(RESULT_VALID),
    .in_ready(RESULT_READY),
    .in_data(RESULT_DATA),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_data)
  );

  ////////////////////////////////////////////////////////////////////////
  // serial engine state

  acp_byte_t cfg [`ACP_CFG_COUNT];
  acp_byte_t next_cfg [`ACP_CFG_COUNT];
  acp_byte_t stage [`ACP_CFG_COUNT];
  acp_byte_t next_stage [`ACP_CFG_COUNT];
  logic [`ACP_CFG_COUNT-1:0] stage_mask, next_stage_mask;
  acp_in_mode_t in_mode, next_in_mode;
  acp_out_mode_t out_mode, next_out_mode;
  logic [2:0] bit_cnt, next_bit_cnt;
  logic [6:0] in_sr, next_in_sr;
  logic [1:0] wr_addr, next_wr_addr, wr_left, next_wr_left;
  logic [1:0] rd_addr, next_rd_addr, rd_left, next_rd_left;
  logic [15:0] out_sr, next_out_sr, result_buf, next_result_buf;
  logic [4:0] out_left, next_out_left;
  logic drive, next_drive, out_bit, next_out_bit;
  logic new_flag, next_new_flag, next_restart;
  logic next_dout, next_amp;
  acp_byte_t next_gain;
  acp_byte_t rx;
  logic busy_read;

  // the pop must not meet an edge: a read that starts in the same cycle
  // would take the old word and then lose the new one
  assign fifo_pop = !new_flag && fifo_valid && !rise && !fall;

  always_comb begin
    next_cfg = cfg;
    next_stage = stage;
    next_stage_mask = stage_mask;
    next_in_mode = in_mode;
    next_out_mode = out_mode;
    next_bit_cnt = bit_cnt;
    next_in_sr = in_sr;
    next_wr_addr = wr_addr;
    next_wr_left = wr_left;
    next_rd_addr = rd_addr;
    next_rd_left = rd_left;
    next_out_sr = out_sr;
    next_result_buf = result_buf;
    next_out_left = out_left;
    next_drive = drive;
    next_out_bit = out_bit;
    next_new_flag = new_flag;
    next_restart = 1'b0;
    rx = {in_sr, din_bit};
    busy_read = (out_mode == OUT_RDATA) || (out_mode == OUT_REGISTER_READ_CMD);

    // a fresh result lands in the data buffer and lowers ready
    if (fifo_pop) begin
      next_result_buf = fifo_data;
      next_new_flag = 1'b1;
    end

    if (!selected) begin
      // deselect abandons any half-sent transfer
      next_bit_cnt = `ACP_BYTE_FIRST;
      next_in_mode = IN_CMD;
      next_out_mode = OUT_IDLE;
      next_out_left = 5'h00;
      next_drive = 1'b0;
    end else if (fall) begin
      // input is sampled on falling edges, commands at byte boundaries
      next_in_sr = rx[6:0];
      next_bit_cnt = bit_cnt + 1'b1;
      if (bit_cnt == `ACP_BYTE_LAST) begin
        case (in_mode)
          IN_WDATA: begin
            next_stage[wr_addr] = rx;
            next_stage_mask[wr_addr] = 1'b1;
            next_wr_addr = wr_addr + 1'b1;
            next_wr_left = wr_left - 1'b1;
            if (wr_left == 2'h0) begin
              // all bytes in: commit together on this last edge
              for (int i = 0; i < `ACP_CFG_COUNT; i++) begin
                if (next_stage_mask[i]) begin
                  next_cfg[i] = next_stage[i];
                end
              end
              next_restart = 1'b1;
              next_in_mode = IN_CMD;
            end
          end
          IN_CMD: begin
            // bytes during a conversion read are decoded too
            if (!busy_read) begin
              case (rx[7:4])
                `ACP_OP_RDATA: begin
                  next_out_mode = OUT_RDATA;
                  next_out_sr = result_buf;
                  next_out_left = `ACP_RESULT_BITS;
                  next_new_flag = 1'b0;
                end
                `ACP_OP_REGISTER_READ_CMD: begin
                  next_out_mode = OUT_REGISTER_READ_CMD;
                  next_out_sr = {cfg[rx[3:2]], 8'h00};
                  next_out_left = `ACP_BYTE_FIRST + 5'h08;
                  next_rd_addr = rx[3:2] + 1'b1;
                  next_rd_left = rx[1:0];
                end
                `ACP_OP_REGISTER_WRITE_CMD: begin
                  // output side untouched, a conversion read goes on
                  next_in_mode = IN_WDATA;
                  next_wr_addr = rx[3:2];
                  next_wr_left = rx[1:0];
                  next_stage_mask = '0;
                end
                default: begin
                  next_in_mode = IN_CMD;
                end
              endcase
            end
          end
          default: begin
            next_in_mode = IN_CMD;
          end
        endcase
      end
    end else if (rise) begin
      // output changes on rising edges, msb first
      case (out_mode)
        OUT_IDLE: begin
          if (bit_cnt == `ACP_BYTE_FIRST && new_flag) begin
            next_out_mode = OUT_CONV;
            next_out_bit = result_buf[15];
            next_out_sr = {result_buf[14:0], 1'b0};
            next_out_left = `ACP_RESULT_REST;
            next_drive = 1'b1;
            next_new_flag = 1'b0;
          end else begin
            next_drive = 1'b0;
          end
        end
        OUT_CONV, OUT_RDATA, OUT_REGISTER_READ_CMD: begin
          next_drive = 1'b1;
          if (out_left != 5'h00) begin
            next_out_bit = out_sr[15];
            next_out_sr = {out_sr[14:0], 1'b0};
            next_out_left = out_left - 1'b1;
          end else if (out_mode == OUT_REGISTER_READ_CMD && rd_left != 2'h0) begin
            // next register follows with no gap
            next_out_bit = cfg[rd_addr][7];
            next_out_sr = {cfg[rd_addr][6:0], 9'h000};
            next_out_left = `ACP_REG_REST;
            next_rd_addr = rd_addr + 1'b1;
            next_rd_left = rd_left - 1'b1;
          end else if (out_mode == OUT_REGISTER_READ_CMD) begin
            next_out_mode = OUT_IDLE;
            next_drive = 1'b0;
          end else begin
            // result read: eight low clocks, then eight high
            next_out_mode = OUT_TAIL;
            next_out_bit = 1'b0;
            next_out_left = `ACP_TAIL_REST;
          end
        end
        OUT_TAIL: begin
          if (out_left != 5'h00) begin
            next_out_bit = out_left <= `ACP_TAIL_HIGH_FROM;
            next_out_left = out_left - 1'b1;
          end else begin
            next_out_mode = OUT_IDLE;
            next_drive = 1'b0;
          end
        end
        default: begin
          next_out_mode = OUT_IDLE;
          next_drive = 1'b0;
        end
      endcase
    end

    // idle line shows ready only when ready-on-out is chosen
    if (next_drive) begin
      next_dout = next_out_bit;
    end else if (cfg[`ACP_ADDR_ROUTE_READY][`ACP_READY_SEL_BIT]) begin
      next_dout = !next_new_flag;
    end else begin
      next_dout = 1'b1;
    end
    next_amp = amp_on(next_cfg[`ACP_ADDR_INPUT_GAIN]);
    next_gain = gain_of(next_cfg[`ACP_ADDR_INPUT_GAIN]
      [`ACP_GAIN_HI:`ACP_GAIN_LO]);
  end

  // only SYS_RST clears the bank; otherwise only a completed register write changes it
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      for (int i = 0; i < `ACP_CFG_COUNT; i++) begin
        cfg[i] <= `ACP_CFG_RESET;
        stage[i] <= `ACP_CFG_RESET;
      end
      stage_mask <= '0;
      in_mode <= IN_CMD;
      out_mode <= OUT_IDLE;
      bit_cnt <= `ACP_BYTE_FIRST;
      in_sr <= 7'h00;
      wr_addr <= 2'h0;
      wr_left <= 2'h0;
      rd_addr <= 2'h0;
      rd_left <= 2'h0;
      out_sr <= 16'h0000;
      result_buf <= 16'h0000;
      out_left <= 5'h00;
      drive <= 1'b0;
      out_bit <= 1'b0;
      new_flag <= 1'b0;
      FILTER_RESTART <= 1'b0;
      DOUT_O <= 1'b1;
      DOUT_OE <= 1'b0;
      RDY_N <= 1'b1;
      AMP_ENABLE <= 1'b1;
      GAIN_FACTOR <= 8'h01;
    end else begin
      cfg <= next_cfg;
      stage <= next_stage;
      stage_mask <= next_stage_mask;
      in_mode <= next_in_mode;
      out_mode <= next_out_mode;
      bit_cnt <= next_bit_cnt;
      in_sr <= next_in_sr;
      wr_addr <= next_wr_addr;
      wr_left <= next_wr_left;
      rd_addr <= next_rd_addr;
      rd_left <= next_rd_left;
      out_sr <= next_out_sr;
      result_buf <= next_result_buf;
      out_left <= next_out_left;
      drive <= next_drive;
      out_bit <= next_out_bit;
      new_flag <= next_new_flag;
      FILTER_RESTART <= next_restart;
      DOUT_O <= next_dout;
      DOUT_OE <= selected;
      RDY_N <= !next_new_flag;
      AMP_ENABLE <= next_amp;
      GAIN_FACTOR <= next_gain;
    end
  end

  // configuration leaves straight from the bank flops
  assign CFG_INPUT_GAIN = cfg[`ACP_ADDR_INPUT_GAIN];
  assign CFG_RATE_MODE = cfg[`ACP_ADDR_RATE_MODE];
  assign CFG_REF_FILTER = cfg[`ACP_ADDR_REF_FILTER];
  assign CFG_ROUTE_READY = cfg[`ACP_ADDR_ROUTE_READY];

endmodule : acp_port
`default_nettype wire

// ---- tb/acp_host_model.sv ----
// host controller model driving the mode-1 serial link of the port
// assumes the bench reads the combined line through dout_line
`timescale 1ns/1ps
`default_nettype none

module acp_host (
  // serial lines towards the port
  output logic sclk,
  output logic cs_n,
  output logic din,
  // combined data/ready line as seen on the board
  input wire logic dout_line
);
  // link idles with clock low and the port deselected
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    din = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // framing: one full link period of margin each side of the clocks
  task sel;
    cs_n = 1'b0;
    #200;
  endtask : sel

  task desel;
    #200;
    cs_n = 1'b1;
    din = 1'b0;
    #400;
  endtask : desel

  // one byte, msb first; data changes on the rise and is read late in
  // the low phase, since the port answers several core cycles late
  task xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int b = 7; b >= 0; b--) begin
      sclk = 1'b1;
      din = tx[b];
      #100;
      sclk = 1'b0;
      #95;
      rx[b] = dout_line;
      #5;
    end
  endtask : xfer
endmodule : acp_host

`default_nettype wire

// ---- tb/acp_port_properties.sv ----
// concurrent checks on the ports of the serial command port
// assumes one core clock domain and a synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none

module acp_port_checker (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic SYS_RST,
  // serial link
  input wire logic SCLK,
  input wire logic CS_N,
  input wire logic DOUT_O,
  input wire logic DOUT_OE,
  input wire logic RDY_N,
  // configuration outputs
  input wire logic [7:0] CFG_INPUT_GAIN,
  input wire logic [7:0] CFG_ROUTE_READY,
  input wire logic [7:0] GAIN_FACTOR,
  input wire logic AMP_ENABLE,
  input wire logic FILTER_RESTART
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (SYS_RST);

  // runs long enough to cover the three-cycle synchroniser lag
  sequence cs_high_run; CS_N [*5]; endsequence
  sequence cs_low_run; !CS_N [*5]; endsequence
  sequence ready_idle; (CFG_ROUTE_READY[1] && DOUT_OE && !SCLK) [*7];
  endsequence

  ////////////////////////////////////////////////////////////////////////
  a_line_released: assert property (cs_high_run |-> !DOUT_OE)
    else $error("combined line driven while deselected");
  a_line_driven: assert property (cs_low_run |-> DOUT_OE)
    else $error("combined line not driven while selected");
  a_ready_held: assert property (CS_N [*4] ##0 !RDY_N |=> !RDY_N)
    else $error("ready pin lost its result while deselected");
  a_ready_on_line: assert property (ready_idle |-> DOUT_O == RDY_N)
    else $error("combined line disagrees with ready pin");
  a_restart_single: assert property (FILTER_RESTART |=> !FILTER_RESTART)
    else $error("filter restart longer than one cycle");
  a_write_restarts: assert property (
    $changed(CFG_INPUT_GAIN) |-> ##[0:2] FILTER_RESTART)
    else $error("register update without filter restart");
  a_cfg_quiet: assert property (CS_N [*8] |->
    $stable(CFG_INPUT_GAIN) && $stable(CFG_ROUTE_READY))
    else $error("registers changed while deselected");
  a_gain_factor: assert property ($stable(CFG_INPUT_GAIN) |->
    GAIN_FACTOR == (8'h01 << CFG_INPUT_GAIN[3:1]))
    else $error("gain factor does not follow gain code");
  a_amp_enable: assert property ($stable(CFG_INPUT_GAIN) |->
    AMP_ENABLE == !(CFG_INPUT_GAIN[0] && CFG_INPUT_GAIN[3:1] <= 3'h2))
    else $error("amplifier enable wrong for gain and bypass");
endmodule : acp_port_checker

bind acp_port acp_port_checker u_acp_port_checker (
  .CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST), .SCLK(SCLK), .CS_N(CS_N),
  .DOUT_O(DOUT_O), .DOUT_OE(DOUT_OE), .RDY_N(RDY_N),
  .CFG_INPUT_GAIN(CFG_INPUT_GAIN), .CFG_ROUTE_READY(CFG_ROUTE_READY),
  .GAIN_FACTOR(GAIN_FACTOR), .AMP_ENABLE(AMP_ENABLE),
  .FILTER_RESTART(FILTER_RESTART)
);

`default_nettype wire

// ---- tb/adc_serial_command_port_tb.sv ----
// self-checking bench for the serial command port
// assumes acp_host drives the link and the checker is bound to the port
`timescale 1ns/1ps
`default_nettype none

module adc_serial_command_port_tb;
  localparam int DEPTH = 4;
  logic core_clk, sys_rst, sclk, cs_n, din, dout_o, dout_oe, rdy_n;
  logic result_valid, result_ready, amp_enable, filter_restart;
  logic [15:0] result_data;
  logic [7:0] cfg_ig, cfg_rm, cfg_rf, cfg_rr, gain_factor, rx;
  logic [7:0] wr_val [4] = '{8'hF5, 8'hA7, 8'h3C, 8'hE0};
  wire logic dout_line;
  int errors = 0;
  int check_count = 0;
  int restarts = 0;

  // a released line shows the inverse of dout_o, never the level dout_o drives
  assign dout_line = dout_oe ? dout_o : ~dout_o;

  acp_port #(.FIFO_DEPTH(DEPTH)) uut (
    .CORE_CLK(core_clk), .SYS_RST(sys_rst), .SCLK(sclk), .CS_N(cs_n),
    .DIN(din), .DOUT_O(dout_o), .DOUT_OE(dout_oe), .RDY_N(rdy_n),
    .RESULT_VALID(result_valid), .RESULT_READY(result_ready),
    .RESULT_DATA(result_data), .CFG_INPUT_GAIN(cfg_ig),
    .CFG_RATE_MODE(cfg_rm), .CFG_REF_FILTER(cfg_rf),
    .CFG_ROUTE_READY(cfg_rr), .GAIN_FACTOR(gain_factor),
    .AMP_ENABLE(amp_enable), .FILTER_RESTART(filter_restart)
  );
  acp_host host (.sclk(sclk), .cs_n(cs_n), .din(din), .dout_line(dout_line));

  // 40 MHz core clock
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  // count restart pulses so each write can be matched to one
  always @(posedge core_clk) begin
    if (filter_restart === 1'b1) restarts++;
  end

  ////////////////////////////////////////////////////////////////////////
  task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk

  task finish_test;
    $display("checks %0d, errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : finish_test

  task wait_rdy;
    int i;
    i = 0;
    while (rdy_n !== 1'b0 && i < 400) begin
      @(posedge core_clk);
      i++;
    end
    chk("ready pin", 16'h0000, 16'(rdy_n));
    if (rdy_n !== 1'b0) finish_test();
  endtask : wait_rdy

  task push(input logic [15:0] w);
    @(posedge core_clk);
    #1 result_valid = 1'b1;
    result_data = w;
    @(posedge core_clk);
    #1 result_valid = 1'b0;
  endtask : push

  task wr1(input logic [1:0] a, input logic [7:0] d);
    host.sel();
    host.xfer({4'h4, a, 2'h0}, rx);
    host.xfer(d, rx);
    host.desel();
  endtask : wr1

  // two result bytes, then the sixteen extra clocks with input low
  task conv_read(input logic [15:0] w, input logic [7:0] t0,
                 input logic [7:0] t1);
    host.xfer(t0, rx);
    chk("result high", 16'(w[15:8]), 16'(rx));
    host.xfer(t1, rx);
    chk("result low", 16'(w[7:0]), 16'(rx));
    host.xfer(8'h00, rx);
    chk("tail low", 16'h0000, 16'(rx));
    host.xfer(8'h00, rx);
    chk("tail high", 16'h00FF, 16'(rx));
  endtask : conv_read

  ////////////////////////////////////////////////////////////////////////
  task t_reset;
    chk("regs", 16'h0000, {cfg_ig | cfg_rm, cfg_rf | cfg_rr});
    chk("gain", 16'h0001, 16'(gain_factor));
    chk("amp", 16'h0001, 16'(amp_enable));
    chk("outs", 16'h0005, {rdy_n, dout_oe, result_ready});
  endtask : t_reset

  // four-byte write from address 0, read back; unused input code F kept
  task t_regs;
    int r0;
    r0 = restarts;
    host.sel();
    host.xfer(8'h43, rx);
    for (int i = 0; i < 4; i++) host.xfer(wr_val[i], rx);
    host.desel();
    chk("reg0", 16'(wr_val[0]), 16'(cfg_ig));
    chk("reg1", 16'(wr_val[1]), 16'(cfg_rm));
    chk("reg2", 16'(wr_val[2]), 16'(cfg_rf));
    chk("reg3", 16'(wr_val[3]), 16'(cfg_rr));
    chk("restart", 16'(r0 + 1), 16'(restarts));
    chk("amp", 16'h0000, 16'(amp_enable));
    host.sel();
    host.xfer(8'h23, rx);
    for (int i = 0; i < 4; i++) begin
      host.xfer(8'h00, rx);
      chk("readback", 16'(wr_val[i]), 16'(rx));
    end
    host.desel();
  endtask : t_regs

  task t_gain;
    for (int g = 0; g < 8; g++) begin
      wr1(2'h0, {4'h0, 3'(g), 1'b1});
      chk("gain", 16'(8'h01 << g), 16'(gain_factor));
      chk("amp", 16'(g > 2), 16'(amp_enable));
    end
    // ground-referred input: bypass set and gain kept at two
    wr1(2'h0, 8'h93);
    chk("gain", 16'h0002, 16'(gain_factor));
    chk("amp", 16'h0000, 16'(amp_enable));
    wr1(2'h0, 8'h00);
    chk("amp", 16'h0001, 16'(amp_enable));
  endtask : t_gain

  // fill the buffer until refused, then drain it in order
  task t_fill;
    int n;
    logic tk;
    n = 0;
    @(posedge core_clk);
    #1 result_valid = 1'b1;
    repeat (40) begin
      result_data = 16'h5A00 | 16'(n);
      tk = result_ready;
      @(posedge core_clk);
      #1;
      if (tk) n++;
    end
    result_valid = 1'b0;
    chk("full refusal", 16'h0000, 16'(result_ready));
    // one word sits in the data buffer, the rest wait in the fifo
    chk("words taken", 16'(DEPTH + 1), 16'(n));
    for (int i = 0; i < n; i++) begin
      wait_rdy();
      host.sel();
      conv_read(16'h5A00 | 16'(i), 8'h00, 8'h00);
      host.desel();
    end
    chk("drained", 16'h0001, 16'(rdy_n));
  endtask : t_fill

  // ready shown on the combined line; write sent during a result read
  task t_ready_line;
    wr1(2'h3, 8'h02);
    host.sel();
    chk("line idle", 16'h0001, 16'(dout_line));
    host.desel();
    push(16'h1234);
    wait_rdy();
    host.sel();
    chk("line ready", 16'h0000, 16'(dout_line));
    conv_read(16'h1234, 8'h40, 8'h5E);
    host.desel();
    chk("reg0", 16'h005E, 16'(cfg_ig));
    chk("released", 16'h0000, 16'(dout_oe));
  endtask : t_ready_line

  // read-data command during the first byte restarts the output
  task t_abort;
    push(16'hC3A5);
    wait_rdy();
    host.sel();
    host.xfer(8'h10, rx);
    conv_read(16'hC3A5, 8'h24, 8'h00);
    host.desel();
  endtask : t_abort

  ////////////////////////////////////////////////////////////////////////
  initial begin
    sys_rst = 1'b1;
    result_valid = 1'b0;
    result_data = 16'h0000;
    repeat (10) @(posedge core_clk);
    #1 sys_rst = 1'b0;
    repeat (4) @(posedge core_clk);
    #1;
    t_reset();
    t_regs();
    t_gain();
    t_fill();
    t_ready_line();
    t_abort();
    finish_test();
  end
endmodule : adc_serial_command_port_tb

`default_nettype wire
